// File: frt_params.svh
// Purpose: Offsets, field positions, reset values and codes of the timer control block.
// Assumes: Included by the design module and by the checker.
// Notes: Register offsets are word indices; the byte address is four times the index.
`ifndef FRT_PARAMS_SVH
`define FRT_PARAMS_SVH

`define FRT_IDX_CONTROL 16'hffa0
`define FRT_IDX_STATUS 16'hffa1
`define FRT_IDX_COUNT 16'hffa2
`define FRT_IDX_CAPTURE 16'hffa3
`define FRT_IDX_IRQ_STATUS 16'hffa4
`define FRT_IDX_IRQ_MASK 16'hffa5

`define FRT_CTRL_CKS_LSB 0
`define FRT_CTRL_OEA 2
`define FRT_CTRL_OEB 3
`define FRT_CTRL_OVERFLOW_IRQ_ENABLE 4
`define FRT_CTRL_COMPARE_A_IRQ_ENABLE 5
`define FRT_CTRL_COMPARE_B_IRQ_ENABLE 6
`define FRT_CTRL_CAPTURE_IRQ_ENABLE 7

`define FRT_STAT_ICF 7
`define FRT_STAT_OCFB 3
`define FRT_STAT_OCFA 2
`define FRT_STAT_OVF 1
`define FRT_STAT_FLAGS 8'h8e

`define FRT_EV_CAPTURE 0
`define FRT_EV_CMP_A 1
`define FRT_EV_CMP_B 2
`define FRT_EV_OVERFLOW 3

`define FRT_CONTROL_RESET 8'h00
`define FRT_STATUS_RESET 8'h00
`define FRT_IRQ_MASK_RESET 4'h0

`define FRT_CKS_DIV2 2'h0
`define FRT_CKS_DIV8 2'h1
`define FRT_CKS_DIV32 2'h2
`define FRT_CKS_EXT 2'h3

`define FRT_DIV2_BITS 3'h1
`define FRT_DIV8_BITS 3'h3
`define FRT_DIV32_BITS 3'h5
`define FRT_COUNT_MAX 16'hffff

`endif

// File: frt_pkg.sv
// Purpose: Types shared by the timer control block and its input synchroniser.
// Assumes: frt_params.svh supplies the field positions.
// Notes: The whole state of each module is one packed struct.
package frt_pkg;

    typedef enum logic {BUS_IDLE, BUS_DONE} bus_phase_e;

    typedef struct packed {
        logic [2:0] stage;
    } sync_s;

    typedef struct packed {
        bus_phase_e phase;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] control;
        logic [7:0] flags;
        logic [7:0] armed;
        logic [4:0] prescale;
        logic [15:0] count;
        logic [15:0] capture;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic [3:0] irq_req;
        logic irq;
        logic pin_a;
        logic pin_b;
    } state_s;

endpackage

// File: edge_sync.sv
// Purpose: Brings a pin into the clock domain and reports its rising edges.
// Assumes: The pin is asynchronous to clk_i.
// Notes: Stage 0 is read only by stage 1; edges are found between stages 1 and 2.
`timescale 1ns/1ns
module edge_sync
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic level_i,
    output logic rise_o
);

    frt_pkg::sync_s s_reg;
    frt_pkg::sync_s s_next;

    // Shift the pin through the synchroniser and a history stage.
    always_comb
    begin
        s_next = s_reg;
        s_next.stage = {s_reg.stage[1:0], level_i};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // A rise is a high synchronised level that was low one cycle before.
    assign rise_o = s_reg.stage[1] & ~s_reg.stage[2];

endmodule // edge_sync

// File: frt_ctrl.sv
// Purpose: Control and status logic of a free-running 16-bit timer on a Wishbone slave port.
// Assumes: Classic Wishbone, 32-bit data, 10 MHz clock; compare match pulses come from the same clock.
// Notes: Control and status registers are 8 bits in the low byte; words above read as zero.
`timescale 1ns/1ns
`include "frt_params.svh"

module frt_ctrl
#(
    parameter int ADR_WIDTH = 18
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_clock_i,
    input wire logic capture_pin_i,
    input wire logic compare_a_match_i,
    input wire logic compare_b_match_i,
    output logic compare_a_pin_o,
    output logic compare_b_pin_o,
    output logic [3:0] irq_req_o,
    output logic irq_o
);

    // The whole state is one packed struct: s_reg holds it, s_next is its value after the next edge.
    // Keeping it in one place means the reset branch below must list every field once.
    frt_pkg::state_s s_reg;
    frt_pkg::state_s s_next;

    // Rising edges of the two pins, already two flip-flops away from the pads.
    logic ext_rise;
    logic capture_rise;
    logic [1:0] pin_levels;
    logic [1:0] pin_rises;

    // True when the bus address selects the word at the given index.
    // The two lowest address bits pick a byte inside the word and are ignored here.
    // Byte lanes are judged by the select lines instead, so a narrow access still hits its word.
    function automatic logic hits(input logic [ADR_WIDTH-1:0] adr, input logic [15:0] idx);
        logic [ADR_WIDTH-1:0] byte_adr;
        byte_adr = ADR_WIDTH'({idx, 2'b00});
        hits = (adr[ADR_WIDTH-1:2] == byte_adr[ADR_WIDTH-1:2]);
    endfunction

    // True when the prescaler has run through a whole period of 2**bits cycles.
    // The prescaler is cleared only by reset, so the first tick after a divider change may come early.
    // That costs at most one short period and keeps the count free of stalls.
    function automatic logic period_end(input logic [4:0] pre, input logic [2:0] bits);
        logic [4:0] mask;
        mask = 5'((6'h01 << bits) - 6'h01);
        period_end = ((pre & mask) == mask);
    endfunction

    // Both pins arrive from outside and pass the same synchroniser.
    // Neither pin may reach logic directly: a level caught mid-change would split across
    // the flip-flops that read it. One instance per pin, so both see the same latency.
    // Pin pulses shorter than two clock periods may be missed; the far side must keep them wider.
    assign pin_levels = {capture_pin_i, ext_clock_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_pin_sync
            edge_sync u_sync
            (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .level_i(pin_levels[gi]),
                .rise_o(pin_rises[gi])
            );
        end
    endgenerate

    // Index 0 carries the external clock, index 1 the capture pin.
    // Swapping them would count capture edges, so the order follows pin_levels above.
    assign ext_rise = pin_rises[0];
    assign capture_rise = pin_rises[1];

    // Next-state logic: counting, capture, flags, bus access and requests.
    // Every local below is given a value first, so no path leaves one unassigned.
    // Events last one cycle, except compare events, which follow their match inputs; the flags and the status register make them sticky.
    always_comb
    begin
        logic tick;
        logic access;
        logic wr;
        logic rd;
        logic [1:0] cks;
        logic ev_capture;
        logic ev_cmp_a;
        logic ev_cmp_b;
        logic ev_ovf;
        logic [3:0] events;
        logic [3:0] enabled;
        logic [7:0] flag_set;
        logic [7:0] flag_clr;
        logic [31:0] rdata;

        s_next = s_reg;
        tick = 1'b0;
        access = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        cks = s_reg.control[`FRT_CTRL_CKS_LSB +: 2];
        ev_capture = 1'b0;
        ev_cmp_a = 1'b0;
        ev_cmp_b = 1'b0;
        ev_ovf = 1'b0;
        events = 4'h0;
        enabled = 4'h0;
        flag_set = 8'h00;
        flag_clr = 8'h00;
        rdata = 32'h0000_0000;

        // The prescaler runs freely so a change of divider never stalls the count.
        s_next.prescale = s_reg.prescale + 5'h01;

        // Pick the source that advances the counter.
        // Only one source can tick in a cycle, so the counter moves by at most one.
        case (cks)
            `FRT_CKS_DIV2: tick = period_end(s_reg.prescale, `FRT_DIV2_BITS);
            `FRT_CKS_DIV8: tick = period_end(s_reg.prescale, `FRT_DIV8_BITS);
            `FRT_CKS_DIV32: tick = period_end(s_reg.prescale, `FRT_DIV32_BITS);
            `FRT_CKS_EXT: tick = ext_rise;
            default: tick = 1'b0;
        endcase

        // The counter wraps from all ones to zero and reports the overflow.
        // The overflow event lasts one cycle, the ticking cycle in which the count still shows all ones; zero follows on the next edge.
        if (tick)
        begin
            s_next.count = s_reg.count + 16'h0001;
            ev_ovf = (s_reg.count == `FRT_COUNT_MAX);
        end

        // A capture takes the count before this cycle's increment.
        // Software reading the capture word therefore sees the value the counter showed
        // in the cycle in which the pin edge was recognised.
        ev_capture = capture_rise;
        if (ev_capture)
        begin
            s_next.capture = s_reg.count;
        end

        // Match pulses come from the same clock and need no synchroniser.
        // A match held high for several cycles sets its flag again in each of them.
        ev_cmp_a = compare_a_match_i;
        ev_cmp_b = compare_b_match_i;

        // A request is taken in idle; the done phase keeps one request from acking twice.
        // The answer comes one edge after the request is taken and stands for one cycle.
        // A master that keeps its strobe up past the answer has it taken again in the cycle after the answer.
        case (s_reg.phase)
            frt_pkg::BUS_IDLE:
            begin
                access = wb_cyc_i & wb_stb_i;
                s_next.ack = access;
                if (access)
                begin
                    s_next.phase = frt_pkg::BUS_DONE;
                end
            end
            frt_pkg::BUS_DONE:
            begin
                s_next.ack = 1'b0;
                s_next.phase = frt_pkg::BUS_IDLE;
            end
            default:
            begin
                s_next.ack = 1'b0;
                s_next.phase = frt_pkg::BUS_IDLE;
            end
        endcase

        // Every writable field lives in byte lane 0, so only its select line gates writes.
        wr = access & wb_we_i & wb_sel_i[0];
        rd = access & ~wb_we_i;

        // Read data; unmapped words answer with zero.
        // Unmapped words are acknowledged rather than refused, so a stray access never hangs the bus.
        // Data drops back to zero in the cycle after the answer.
        if (hits(wb_adr_i, `FRT_IDX_CONTROL))
        begin
            rdata = {24'h000000, s_reg.control};
        end
        else if (hits(wb_adr_i, `FRT_IDX_STATUS))
        begin
            rdata = {24'h000000, s_reg.flags};
        end
        else if (hits(wb_adr_i, `FRT_IDX_COUNT))
        begin
            rdata = {16'h0000, s_reg.count};
        end
        else if (hits(wb_adr_i, `FRT_IDX_CAPTURE))
        begin
            rdata = {16'h0000, s_reg.capture};
        end
        else if (hits(wb_adr_i, `FRT_IDX_IRQ_STATUS))
        begin
            rdata = {28'h0000000, s_reg.irq_status};
        end
        else if (hits(wb_adr_i, `FRT_IDX_IRQ_MASK))
        begin
            rdata = {28'h0000000, s_reg.irq_mask};
        end
        if (rd)
        begin
            s_next.rdata = rdata;
        end
        else if (s_reg.phase == frt_pkg::BUS_DONE)
        begin
            s_next.rdata = 32'h0000_0000;
        end

        // A read that sees a flag set arms that flag for clearing.
        // Only flags set at the moment of the read are armed; one that sets later needs a fresh read,
        // so an event that lands between the read and the write is not lost.
        if (rd && hits(wb_adr_i, `FRT_IDX_STATUS))
        begin
            s_next.armed = s_reg.armed | s_reg.flags;
        end

        // Control register: every bit is plain read and write.
        // A new clock select takes effect from the next cycle; the prescaler keeps running.
        if (wr && hits(wb_adr_i, `FRT_IDX_CONTROL))
        begin
            s_next.control = wb_dat_i[7:0];
        end

        // A zero clears only an armed flag; a one leaves the flag alone.
        // Any write to the status word disarms every flag, so a clear needs its own read first.
        if (wr && hits(wb_adr_i, `FRT_IDX_STATUS))
        begin
            flag_clr = ~wb_dat_i[7:0] & s_reg.armed & `FRT_STAT_FLAGS;
            s_next.armed = 8'h00;
        end

        // The mask only gates the summary interrupt; status bits keep collecting events.
        if (wr && hits(wb_adr_i, `FRT_IDX_IRQ_MASK))
        begin
            s_next.irq_mask = wb_dat_i[3:0];
        end

        // Hardware sets after software clears, so an event is never lost.
        // Armed bits follow their flags, so a flag cleared here cannot stay armed.
        flag_set[`FRT_STAT_ICF] = ev_capture;
        flag_set[`FRT_STAT_OCFA] = ev_cmp_a;
        flag_set[`FRT_STAT_OCFB] = ev_cmp_b;
        flag_set[`FRT_STAT_OVF] = ev_ovf;
        s_next.flags = (s_reg.flags & ~flag_clr) | flag_set;
        s_next.armed = s_next.armed & s_next.flags;

        // Sticky interrupt status sees only events whose enable is set.
        // Its clear works by writing ones, unlike the flags, and a new event wins over the clear.
        events[`FRT_EV_CAPTURE] = ev_capture;
        events[`FRT_EV_CMP_A] = ev_cmp_a;
        events[`FRT_EV_CMP_B] = ev_cmp_b;
        events[`FRT_EV_OVERFLOW] = ev_ovf;
        enabled[`FRT_EV_CAPTURE] = s_reg.control[`FRT_CTRL_CAPTURE_IRQ_ENABLE];
        enabled[`FRT_EV_CMP_A] = s_reg.control[`FRT_CTRL_COMPARE_A_IRQ_ENABLE];
        enabled[`FRT_EV_CMP_B] = s_reg.control[`FRT_CTRL_COMPARE_B_IRQ_ENABLE];
        enabled[`FRT_EV_OVERFLOW] = s_reg.control[`FRT_CTRL_OVERFLOW_IRQ_ENABLE];
        if (wr && hits(wb_adr_i, `FRT_IDX_IRQ_STATUS))
        begin
            s_next.irq_status = s_reg.irq_status & ~wb_dat_i[3:0];
        end
        s_next.irq_status = s_next.irq_status | (events & enabled);

        // Requests follow each flag for as long as it and its enable are set.
        // They use the next values so a request drops on the same edge as its flag or enable.
        s_next.irq_req[`FRT_EV_CAPTURE] = s_next.flags[`FRT_STAT_ICF]
            & s_next.control[`FRT_CTRL_CAPTURE_IRQ_ENABLE];
        s_next.irq_req[`FRT_EV_CMP_A] = s_next.flags[`FRT_STAT_OCFA]
            & s_next.control[`FRT_CTRL_COMPARE_A_IRQ_ENABLE];
        s_next.irq_req[`FRT_EV_CMP_B] = s_next.flags[`FRT_STAT_OCFB]
            & s_next.control[`FRT_CTRL_COMPARE_B_IRQ_ENABLE];
        s_next.irq_req[`FRT_EV_OVERFLOW] = s_next.flags[`FRT_STAT_OVF]
            & s_next.control[`FRT_CTRL_OVERFLOW_IRQ_ENABLE];
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);

        // Match pulses reach the pins only through their output enables.
        // The pins repeat the match pulses one edge after the match, for as long as the match stays high, not toggling levels.
        s_next.pin_a = compare_a_match_i & s_reg.control[`FRT_CTRL_OEA];
        s_next.pin_b = compare_b_match_i & s_reg.control[`FRT_CTRL_OEB];
    end

    // All state updates on one edge; reset returns every field to its documented value.
    // Reset is synchronous, so the branch holds constants only and a glitch on the
    // reset line between edges has no effect.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg.phase <= frt_pkg::BUS_IDLE;
            s_reg.ack <= 1'b0;
            s_reg.rdata <= 32'h0000_0000;
            s_reg.control <= `FRT_CONTROL_RESET;
            s_reg.flags <= `FRT_STATUS_RESET;
            s_reg.armed <= 8'h00;
            s_reg.prescale <= 5'h00;
            s_reg.count <= 16'h0000;
            s_reg.capture <= 16'h0000;
            s_reg.irq_status <= 4'h0;
            s_reg.irq_mask <= `FRT_IRQ_MASK_RESET;
            s_reg.irq_req <= 4'h0;
            s_reg.irq <= 1'b0;
            s_reg.pin_a <= 1'b0;
            s_reg.pin_b <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Every output is a flip-flop of the state.
    // No output passes through logic after its register, so the pads see clean edges.
    assign wb_dat_o = s_reg.rdata;
    assign wb_ack_o = s_reg.ack;
    assign compare_a_pin_o = s_reg.pin_a;
    assign compare_b_pin_o = s_reg.pin_b;
    assign irq_req_o = s_reg.irq_req;
    assign irq_o = s_reg.irq;

endmodule // frt_ctrl

// File: frt_ctrl_monitor.sv
// Purpose: Port-level checks of the timer control block.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes: Register contents are not visible here, so checks tie outputs to bus and pin causes.
`timescale 1ns/1ns
`include "frt_params.svh"
module frt_ctrl_monitor
#(
    parameter int ADR_WIDTH = 18
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic ext_clock_i,
    input wire logic capture_pin_i,
    input wire logic compare_a_match_i,
    input wire logic compare_b_match_i,
    input wire logic compare_a_pin_o,
    input wire logic compare_b_pin_o,
    input wire logic [3:0] irq_req_o,
    input wire logic irq_o
);
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Shadow of the control register; the slave takes a request only while ack is low.
    logic [7:0] ctrl_shadow;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_shadow <= 8'h00;
        end
        else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o
            && wb_adr_i[ADR_WIDTH-1:2] == (ADR_WIDTH-2)'(`FRT_IDX_CONTROL))
        begin
            ctrl_shadow <= wb_dat_i[7:0];
        end
    end

    // A request seen while ack is low and was also low in the cycle before, and any write request.
    sequence fresh_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o);
    endsequence
    sequence write_req;
        wb_cyc_i && wb_stb_i && wb_we_i;
    endsequence

    chk_ack_answer: assert property (fresh_req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_dat_clear: assert property (wb_ack_o |=> wb_dat_o == 32'h0)
        else $error("read data not cleared after ack");
    chk_pin_a_cause: assert property (compare_a_pin_o == $past(compare_a_match_i && ctrl_shadow[`FRT_CTRL_OEA]))
        else $error("compare A pin without match");
    chk_pin_b_cause: assert property (compare_b_pin_o == $past(compare_b_match_i && ctrl_shadow[`FRT_CTRL_OEB]))
        else $error("compare B pin without match");
    chk_capture_req_fall: assert property ($fell(irq_req_o[0]) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
        else $error("capture request dropped without a write");
    chk_reset_quiet: assert property ($fell(rst_i) |-> irq_req_o == 4'h0 && !irq_o && !wb_ack_o)
        else $error("outputs not quiet after reset");
    cov_write: cover property (write_req);
endmodule // frt_ctrl_monitor

bind frt_ctrl frt_ctrl_monitor #(.ADR_WIDTH(ADR_WIDTH)) mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clock_i(ext_clock_i), .capture_pin_i(capture_pin_i),
    .compare_a_match_i(compare_a_match_i), .compare_b_match_i(compare_b_match_i),
    .compare_a_pin_o(compare_a_pin_o), .compare_b_pin_o(compare_b_pin_o), .irq_req_o(irq_req_o), .irq_o(irq_o));

// File: frt_pin_model.sv
// Purpose: Drives the external clock and capture pins of the timer.
// Assumes: Called from the bench right after a rising clock edge.
// Notes: Pins stand still between requested activity.
`timescale 1ns/1ns
module frt_pin_model
(
    input wire logic clk_i,
    output logic ext_clock_o,
    output logic capture_o
);
    // Both pins idle low.
    initial
    begin
        ext_clock_o = 1'b0;
        capture_o = 1'b0;
    end

    // Slow pulses, so that each one survives the synchroniser.
    task automatic ext_pulses(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            ext_clock_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            ext_clock_o <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask

    // One rising transition on the capture pin.
    task automatic capture_edge();
        @(posedge clk_i);
        capture_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        capture_o <= 1'b0;
    endtask
endmodule // frt_pin_model

// File: free_running_timer_control_test.sv
// Purpose: Self-checking bench of the timer control block.
// Assumes: Byte address is four times the word index; the bus task fails the run if ack is still missing after 21 edges.
// Notes: Random control values come from a fixed seed.
`timescale 1ns/1ns
module free_running_timer_control_test;
    localparam logic [17:0] A_CTRL = 18'h3fe80;
    localparam logic [17:0] A_STAT = 18'h3fe84;
    localparam logic [17:0] A_CNT = 18'h3fe88;
    localparam logic [17:0] A_CAP = 18'h3fe8c;
    localparam logic [17:0] A_IST = 18'h3fe90;
    localparam logic [17:0] A_IMSK = 18'h3fe94;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, ext_clock, capture_pin;
    logic match_a, match_b, pin_a, pin_b, irq;
    logic [17:0] wb_adr;
    logic [3:0] wb_sel, irq_req;
    logic [31:0] wb_dat_w, wb_dat_r, q, a;
    logic [7:0] r;
    int fails, check_count, n;

    // Free-running 10 MHz clock.
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    frt_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
        .ext_clock_i(ext_clock), .capture_pin_i(capture_pin), .compare_a_match_i(match_a),
        .compare_b_match_i(match_b), .compare_a_pin_o(pin_a), .compare_b_pin_o(pin_b), .irq_req_o(irq_req),
        .irq_o(irq));
    frt_pin_model pins (.clk_i(clk_i), .ext_clock_o(ext_clock), .capture_o(capture_pin));

    // Compares one value and counts the outcome.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One classic cycle held until ack is sampled; returns one idle edge after release.
    task automatic bus(input logic w, input logic [17:0] adr, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_sel <= 4'hf;
        wb_adr <= adr;
        wb_dat_w <= d;
        @(posedge clk_i);
        while (wb_ack !== 1'b1)
        begin
            k++;
            if (k > 20)
            begin
                fails++;
                summarize();
            end
            @(posedge clk_i);
        end
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // Main sequence.
    initial
    begin
        {rst_i, wb_cyc, wb_stb, wb_we, match_a, match_b} = 6'h20;
        wb_adr = 18'h0;
        wb_sel = 4'hf;
        wb_dat_w = 32'h0;
        fails = 0;
        check_count = 0;
        a = $urandom(43);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, A_CTRL, 32'h0);
        check("control reset", 32'h0, q);
        bus(1'b0, A_STAT, 32'h0);
        check("status reset", 32'h0, q);
        bus(1'b0, 18'h00010, 32'h0);
        check("unmapped read", 32'h0, q);
        repeat (6)
        begin
            r = 8'($urandom);
            bus(1'b1, A_CTRL, {24'h0, r});
            bus(1'b0, A_CTRL, 32'h0);
            check("control readback", {24'h0, r}, q);
        end
        // Counts over 128 clocks for each internal divider.
        for (int c = 0; c < 3; c++)
        begin
            bus(1'b1, A_CTRL, 32'(c));
            bus(1'b0, A_CNT, 32'h0);
            a = q;
            repeat (125) @(posedge clk_i);
            bus(1'b0, A_CNT, 32'h0);
            check("internal count step", 32'(128 >> (2 * c + 1)), {16'h0, 16'(q - a)});
        end
        n = 1 + ($urandom % 6);
        bus(1'b1, A_CTRL, 32'h3);
        bus(1'b0, A_CNT, 32'h0);
        a = q;
        pins.ext_pulses(n);
        repeat (6) @(posedge clk_i);
        bus(1'b0, A_CNT, 32'h0);
        check("external count step", 32'(n), {16'h0, 16'(q - a)});
        // With the external clock idle the count stands, so a capture must return it unchanged.
        a = q;
        pins.capture_edge();
        repeat (4) @(posedge clk_i);
        bus(1'b0, A_CAP, 32'h0);
        check("capture value", a, q);
        // Capture with its interrupt off, then on; the read arms the flag.
        bus(1'b1, A_CTRL, 32'h0);
        pins.capture_edge();
        repeat (4) @(posedge clk_i);
        check("capture request off", 32'h0, {31'h0, irq_req[0]});
        bus(1'b0, A_STAT, 32'h0);
        check("capture flag", 32'h80, q & 32'h80);
        bus(1'b1, A_CTRL, 32'h80);
        bus(1'b1, A_STAT, 32'hff);
        bus(1'b1, A_STAT, 32'h0);
        check("flag kept unarmed", 32'h1, {31'h0, irq_req[0]});
        bus(1'b0, A_STAT, 32'h0);
        check("flag after ones", 32'h80, q & 32'h80);
        bus(1'b1, A_STAT, 32'h0);
        @(posedge clk_i);
        check("flag cleared", 32'h0, {31'h0, irq_req[0]});
        // Compare pins and requests under random enables.
        repeat (8)
        begin
            r = 8'($urandom) & 8'h6c;
            bus(1'b1, A_CTRL, {24'h0, r});
            bus(1'b1, A_IST, 32'hf);
            bus(1'b1, A_IMSK, 32'h6);
            match_a <= 1'b1;
            match_b <= 1'b1;
            @(posedge clk_i);
            match_a <= 1'b0;
            match_b <= 1'b0;
            @(posedge clk_i);
            check("compare A pin", {31'h0, r[2]}, {31'h0, pin_a});
            check("compare B pin", {31'h0, r[3]}, {31'h0, pin_b});
            repeat (3) @(posedge clk_i);
            check("compare requests", {30'h0, r[6:5]}, {30'h0, irq_req[2:1]});
            check("masked interrupt", {31'h0, |r[6:5]}, {31'h0, irq});
            bus(1'b0, A_STAT, 32'h0);
            bus(1'b1, A_STAT, 32'h0);
        end
        bus(1'b1, A_IST, 32'hf);
        @(posedge clk_i);
        check("interrupt cleared", 32'h0, {31'h0, irq});
        summarize();
    end
endmodule // free_running_timer_control_test
